// ===== design/vbl_bit_tx.sv
// Serial bit shaper: preparation, sync, data and halt periods per bit.
// Assumes a same-clock request; a bit starts only while idle.
`timescale 1ns/1ps
`default_nettype none
module vbl_bit_tx
  import vbl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bit request
  input wire logic start_i,
  input wire logic bit_i,
  output logic busy_o,
  output logic done_o,
  // Logic level of the line
  output logic line_o
);
  typedef struct packed {
    logic busy;
    vbl_phase_t phase;
    logic [7:0] cnt;
    logic bitv;
    logic line;
    logic done;
  } vbl_tx_state_t;

  vbl_tx_state_t s_reg;
  vbl_tx_state_t s_next;

  // period lengths as parameters
  // Period length of the current phase
  function automatic logic [7:0] plen(input vbl_phase_t ph);
    case (ph)
      VBL_PH_PREP: plen = 8'(VBL_PREP_CYC);
      VBL_PH_SYNC: plen = 8'(VBL_SYNC_CYC);
      VBL_PH_DATA: plen = 8'(VBL_DATA_CYC);
      default: plen = 8'(VBL_HALT_CYC);
    endcase
  endfunction

  // Phase sequencer
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.busy) begin
      s_next.line = 1'b1;
      if (start_i) begin
        s_next.busy = 1'b1;
        s_next.phase = VBL_PH_PREP;
        s_next.cnt = 8'h01;
        s_next.bitv = bit_i;
      end
    end else if (s_reg.cnt >= plen(s_reg.phase)) begin
      s_next.cnt = 8'h01;
      case (s_reg.phase)
        VBL_PH_PREP: begin
          s_next.phase = VBL_PH_SYNC;
          s_next.line = 1'b0;
        end
        VBL_PH_SYNC: begin
          s_next.phase = VBL_PH_DATA;
          s_next.line = s_reg.bitv;
        end
        VBL_PH_DATA: begin
          s_next.phase = VBL_PH_HALT;
          s_next.line = 1'b1;
        end
        default: begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          s_next.phase = VBL_PH_PREP;
        end
      endcase
    end else begin
      s_next.cnt = s_reg.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{busy: 1'b0, phase: VBL_PH_PREP, cnt: 8'h00, bitv: 1'b0, line: 1'b1, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_o = s_reg.busy;
  assign done_o = s_reg.done;
  assign line_o = s_reg.line;
endmodule
`default_nettype wire

// ===== design/vbl_lock_ctrl.sv
// Slave lock handling, control-code dispatch, pin routing and bit output.
// Assumes a frame decoder on the same clock reporting frame events, and
// a classic Wishbone master for the registers.
// Frame event inputs are one-cycle pulses on the same clock.
// Broadcast frames pass data on but never change the lock.
//
// Contract
// - Data-read codes send the transmit data buffer to the master.
// - Data and command writes pass received bytes to the application.
// - Locked-address reads return 12-bit locking master address in two bytes.
// - While locked, accept data only from the locking master.
// - Lock code acked, frame ends short: lock and set status bit 2.
// - Lock only on byte count overflow; other errors leave lock unchanged.
// - Lock or unlock code with full byte count in frame clears lock.
// - Broadcast frames never set or clear the lock.
// - Reset, module stop or software unlock command release the lock.
// - General flag register shows the locked flag.
// - Each bit: preparation 1, sync 0, data value, halt 1.
// - Sync and data periods about equal in length.
// - Resynchronise each bit; timing differs by bit kind and role. The shaper here uses one fixed set of period lengths for every bit.
// - Transmit on a dedicated output pin, receive from a dedicated input.
// - Control bit 7 routes pins to port functions or to the bus.
// - Control bit 6 selects pin polarity; 0 means active low.
// - Locked: refuse non-locker codes except status and address reads.
// - Control code bit 3 gives the direction; 1 is master to slave.
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vbl_lock_ctrl
  import vbl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic module_stop_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Frame events from the decoder
  input wire logic ctl_valid_i,
  input wire logic [3:0] ctl_code_i,
  input wire logic [11:0] ctl_master_i,
  input wire logic ctl_broadcast_i,
  input wire logic len_ack_i,
  input wire logic frame_end_i,
  input wire logic frame_complete_i,
  input wire logic frame_overflow_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic tx_byte_req_i,
  // Answers to the decoder and received bytes for the application
  output logic ctl_ack_o,
  output logic ctl_dir_m2s_o,
  output logic [7:0] tx_byte_o,
  output logic tx_byte_valid_o,
  output logic rx_app_valid_o,
  output logic [7:0] rx_app_byte_o,
  output logic rx_app_cmd_o,
  // Bit shaper request
  input wire logic bit_start_i,
  input wire logic bit_value_i,
  output logic bit_busy_o,
  output logic bit_done_o,
  // Pins
  output logic bus_tx_o,
  input wire logic bus_rx_i,
  output logic rx_logic_o,
  output logic port_mode_o
);
  typedef struct packed {
    logic [7:0] ctl;
    logic locked;
    logic [11:0] lock_addr;
    logic [7:0] tx_data;
    logic tx_full;
    logic [7:0] rx_data;
    logic rx_full;
    logic [3:0] code;
    logic active;
    logic acked;
    logic ack;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic [7:0] app_byte;
    logic app_valid;
    logic app_cmd;
    logic [31:0] rdat;
    logic wb_ack;
    logic rx_s1;
    logic rx_s2;
    logic bcast;
  } vbl_state_t;

  vbl_state_t s_reg;
  vbl_state_t s_next;
  logic line;
  logic wb_req;
  logic [7:0] slave_status_byte;
  logic allowed;
  logic tx_level;
  logic rx_level;

  vbl_bit_tx u_bit_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(bit_start_i),
    .bit_i(bit_value_i),
    .busy_o(bit_busy_o),
    .done_o(bit_done_o),
    .line_o(line)
  );

  // One request per access; a pending ack blocks a second
  assign wb_req = wb_cyc_i && wb_stb_i && !s_reg.wb_ack;

  // Slave status byte
  always_comb begin
    slave_status_byte = 8'h00;
    slave_status_byte[7:6] = VBL_SSR_MODE;
    slave_status_byte[VBL_SSR_LOCK_BIT] = s_reg.locked;
    slave_status_byte[VBL_SSR_RXNE_BIT] = s_reg.rx_full;
    slave_status_byte[VBL_SSR_TXNE_BIT] = s_reg.tx_full;
  end

  // Control codes accepted by this slave
  always_comb begin
    case (ctl_code_i)
      VBL_CC_STATUS, VBL_CC_ADDR_LO, VBL_CC_ADDR_HI: allowed = 1'b1;
      VBL_CC_READ_LOCK, VBL_CC_STATUS_UNLOCK, VBL_CC_READ, VBL_CC_CMD_LOCK,
      VBL_CC_WRITE_LOCK, VBL_CC_CMD, VBL_CC_WRITE:
        allowed = !s_reg.locked || (ctl_master_i == s_reg.lock_addr);
      // Undefined codes are never acknowledged
      default: allowed = 1'b0;
    endcase
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    // Clear one-cycle pulses by default
    s_next.wb_ack = 1'b0;
    s_next.ack = 1'b0;
    s_next.tx_valid = 1'b0;
    s_next.app_valid = 1'b0;
    // Two-flop synchroniser for the receive pin
    s_next.rx_s1 = bus_rx_i;
    s_next.rx_s2 = s_reg.rx_s1;
    // Control field decode
    if (ctl_valid_i) begin
      s_next.code = ctl_code_i;
      s_next.active = allowed;
      s_next.bcast = ctl_broadcast_i;
      s_next.acked = 1'b0;
      // No acknowledge is returned to a broadcast
      s_next.ack = allowed && !ctl_broadcast_i;
    end
    // Length acknowledged; a short frame may now lock
    if (len_ack_i && s_reg.active) begin
      s_next.acked = 1'b1;
    end
    // Byte supply for slave-to-master fields
    if (tx_byte_req_i && s_reg.active) begin
      s_next.tx_valid = 1'b1;
      case (s_reg.code)
        VBL_CC_READ, VBL_CC_READ_LOCK: begin
          s_next.tx_byte = s_reg.tx_data;
          s_next.tx_full = 1'b0;
        end
        VBL_CC_ADDR_LO: s_next.tx_byte = s_reg.lock_addr[7:0];
        VBL_CC_ADDR_HI: s_next.tx_byte = {4'h0, s_reg.lock_addr[11:8]};
        // Status reads send the slave status byte
        default: s_next.tx_byte = slave_status_byte;
      endcase
    end
    if (rx_byte_valid_i && s_reg.active && s_reg.code[VBL_CC_DIR_BIT]) begin
      s_next.app_valid = 1'b1;
      s_next.app_byte = rx_byte_i;
      s_next.app_cmd = !s_reg.code[0];
      s_next.rx_data = rx_byte_i;
      s_next.rx_full = 1'b1;
    end
    // Frame end closes the transfer
    if (frame_end_i) begin
      s_next.active = 1'b0;
    end
    // broadcast frames leave the lock alone
    if (frame_end_i && s_reg.active && !s_reg.bcast) begin
      case (s_reg.code)
        VBL_CC_READ_LOCK, VBL_CC_CMD_LOCK, VBL_CC_WRITE_LOCK: begin
          if (s_reg.acked && frame_overflow_i && !frame_complete_i) begin
            s_next.locked = 1'b1;
            s_next.lock_addr = ctl_master_i;
          end else if (frame_complete_i) begin
            s_next.locked = 1'b0;
          end
        end
        VBL_CC_STATUS_UNLOCK: begin
          if (frame_complete_i) begin
            s_next.locked = 1'b0;
          end
        end
        // Plain reads and writes keep the lock
        default: ;
      endcase
    end
    // Register access
    if (wb_req) begin
      s_next.wb_ack = 1'b1;
      // Read data is the low byte, zero-extended
      s_next.rdat = 32'h0000_0000;
      case (wb_adr_i)
        VBL_OFS_CONTROL: s_next.rdat[7:0] = s_reg.ctl;
        VBL_OFS_FLAG: s_next.rdat[VBL_FLG_LOCKED_BIT] = s_reg.locked;
        VBL_OFS_LOCK_LO: s_next.rdat[7:0] = s_reg.lock_addr[7:0];
        VBL_OFS_LOCK_HI: s_next.rdat[3:0] = s_reg.lock_addr[11:8];
        VBL_OFS_TX_DATA: s_next.rdat[7:0] = s_reg.tx_data;
        VBL_OFS_RX_DATA: s_next.rdat[7:0] = s_reg.rx_data;
        // Unmapped offsets read as zero
        default: ;
      endcase
      // A byte arriving in the same cycle keeps the buffer full
      if (!wb_we_i && wb_adr_i == VBL_OFS_RX_DATA && !s_next.app_valid) begin
        s_next.rx_full = 1'b0;
      end
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          VBL_OFS_CONTROL: s_next.ctl = wb_dat_i[7:0];
          VBL_OFS_COMMAND: if (wb_dat_i[7:0] == VBL_CMD_UNLOCK) s_next.locked = 1'b0;
          VBL_OFS_TX_DATA: begin
            s_next.tx_data = wb_dat_i[7:0];
            s_next.tx_full = 1'b1;
          end
          // Other offsets are read-only or unused
          default: ;
        endcase
      end
    end
    // module stop releases lock
    // Stop also ends any transfer in progress
    if (module_stop_i) begin
      s_next.locked = 1'b0;
      s_next.active = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      // Control register back to its reset value
      s_reg.ctl <= VBL_CTL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    tx_level = !line;
    rx_level = !s_reg.rx_s2;
    // Active-high pins carry the logic level unchanged
    if (s_reg.ctl[VBL_CTL_POLARITY_BIT]) begin
      tx_level = line;
      rx_level = s_reg.rx_s2;
    end
  end

  // pin route switch
  // Transmit pin held low while the pins serve the port
  assign bus_tx_o = s_reg.ctl[VBL_CTL_PIN_SWITCH_BIT] ? tx_level : 1'b0;
  assign rx_logic_o = rx_level;
  assign port_mode_o = !s_reg.ctl[VBL_CTL_PIN_SWITCH_BIT];
  // Transfer outputs come straight from the state
  // direction from bit 3
  assign ctl_dir_m2s_o = s_reg.code[VBL_CC_DIR_BIT];
  assign ctl_ack_o = s_reg.ack;
  assign tx_byte_o = s_reg.tx_byte;
  assign tx_byte_valid_o = s_reg.tx_valid;
  assign rx_app_valid_o = s_reg.app_valid;
  assign rx_app_byte_o = s_reg.app_byte;
  assign rx_app_cmd_o = s_reg.app_cmd;
  assign wb_dat_o = s_reg.rdat;
  assign wb_ack_o = s_reg.wb_ack;
endmodule
`default_nettype wire

// ===== design/vbl_pkg.sv
// Package for the vehicle-bus lock and bit-format block.
// Assumes a 125 MHz system clock and classic Wishbone register access.
package vbl_pkg;
  // Register byte offsets
  localparam logic [7:0] VBL_OFS_CONTROL = 8'h00;
  localparam logic [7:0] VBL_OFS_COMMAND = 8'h04;
  localparam logic [7:0] VBL_OFS_FLAG = 8'h08;
  localparam logic [7:0] VBL_OFS_LOCK_LO = 8'h0c;
  localparam logic [7:0] VBL_OFS_LOCK_HI = 8'h10;
  localparam logic [7:0] VBL_OFS_TX_DATA = 8'h14;
  localparam logic [7:0] VBL_OFS_RX_DATA = 8'h18;
  localparam logic [7:0] VBL_OFS_OWN_ADDR = 8'h1c;
  // Control register fields
  localparam int VBL_CTL_PIN_SWITCH_BIT = 7;
  localparam int VBL_CTL_POLARITY_BIT = 6;
  localparam logic [7:0] VBL_CTL_RESET = 8'h00;
  // Command register: write this value to drop the lock
  localparam logic [7:0] VBL_CMD_UNLOCK = 8'h01;
  // Flag register field
  localparam int VBL_FLG_LOCKED_BIT = 0;
  // Slave status byte layout
  localparam int VBL_SSR_LOCK_BIT = 2;
  localparam int VBL_SSR_RXNE_BIT = 1;
  localparam int VBL_SSR_TXNE_BIT = 0;
  localparam logic [1:0] VBL_SSR_MODE = 2'h2;
  // Control codes
  localparam logic [3:0] VBL_CC_STATUS = 4'h0;
  localparam logic [3:0] VBL_CC_READ_LOCK = 4'h3;
  localparam logic [3:0] VBL_CC_ADDR_LO = 4'h4;
  localparam logic [3:0] VBL_CC_ADDR_HI = 4'h5;
  localparam logic [3:0] VBL_CC_STATUS_UNLOCK = 4'h6;
  localparam logic [3:0] VBL_CC_READ = 4'h7;
  localparam logic [3:0] VBL_CC_CMD_LOCK = 4'ha;
  localparam logic [3:0] VBL_CC_WRITE_LOCK = 4'hb;
  localparam logic [3:0] VBL_CC_CMD = 4'he;
  localparam logic [3:0] VBL_CC_WRITE = 4'hf;
  localparam int VBL_CC_DIR_BIT = 3;
  // Bit period timing, each period in ns
  localparam int VBL_CLK_NS = 8;
  localparam int VBL_PREP_NS = 80;
  localparam int VBL_SYNC_NS = 160;
  localparam int VBL_DATA_NS = 160;
  localparam int VBL_HALT_NS = 40;
  localparam int VBL_PREP_CYC = (VBL_PREP_NS + VBL_CLK_NS - 1) / VBL_CLK_NS;
  localparam int VBL_SYNC_CYC = (VBL_SYNC_NS + VBL_CLK_NS - 1) / VBL_CLK_NS;
  localparam int VBL_DATA_CYC = (VBL_DATA_NS + VBL_CLK_NS - 1) / VBL_CLK_NS;
  localparam int VBL_HALT_CYC = (VBL_HALT_NS + VBL_CLK_NS - 1) / VBL_CLK_NS;
  // Bit period phases
  typedef enum logic [1:0] {
    VBL_PH_PREP = 2'b00,
    VBL_PH_SYNC = 2'b01,
    VBL_PH_DATA = 2'b11,
    VBL_PH_HALT = 2'b10
  } vbl_phase_t;
endpackage

// ===== sim/tb_vbl_lock_ctrl.sv
// Self-checking bench for the lock controller.
// Assumes a 125 MHz clock and the frame model standing for other units.
`timescale 1ns/1ps
`default_nettype none
module tb_vbl_lock_ctrl;
  import vbl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic module_stop_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic bit_start_i = 1'b0;
  logic bit_value_i = 1'b0;
  logic bus_rx_i = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, ctl_ack_o, ctl_dir_m2s_o, tx_byte_valid_o, rx_app_valid_o, rx_app_cmd_o, ak, app_c;
  logic bit_busy_o, bit_done_o, bus_tx_o, rx_logic_o, port_mode_o;
  logic [7:0] tx_byte_o, rx_app_byte_o, rx_byte_i, app_b;
  logic ctl_valid_i, ctl_broadcast_i, len_ack_i, frame_end_i, frame_complete_i, frame_overflow_i;
  logic rx_byte_valid_i, tx_byte_req_i;
  logic [3:0] ctl_code_i;
  logic [11:0] ctl_master_i;
  int n_fail = 0;
  int compares = 0;
  always #4 clk_i = ~clk_i;
  vbl_lock_ctrl dut (.clk_i, .rst_i, .module_stop_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ctl_valid_i, .ctl_code_i, .ctl_master_i, .ctl_broadcast_i, .len_ack_i,
    .frame_end_i, .frame_complete_i, .frame_overflow_i, .rx_byte_valid_i, .rx_byte_i, .tx_byte_req_i, .ctl_ack_o,
    .ctl_dir_m2s_o, .tx_byte_o, .tx_byte_valid_o, .rx_app_valid_o, .rx_app_byte_o, .rx_app_cmd_o, .bit_start_i,
    .bit_value_i, .bit_busy_o, .bit_done_o, .bus_tx_o, .bus_rx_i, .rx_logic_o, .port_mode_o);
  vbl_unit_model um (.clk_i, .ctl_valid_o(ctl_valid_i), .ctl_code_o(ctl_code_i), .ctl_master_o(ctl_master_i),
    .ctl_broadcast_o(ctl_broadcast_i), .len_ack_o(len_ack_i), .frame_end_o(frame_end_i),
    .frame_complete_o(frame_complete_i), .frame_overflow_o(frame_overflow_i), .rx_byte_valid_o(rx_byte_valid_i),
    .rx_byte_o(rx_byte_i), .tx_byte_req_o(tx_byte_req_i), .ctl_ack_i(ctl_ack_o), .tx_byte_valid_i(tx_byte_valid_o),
    .tx_byte_i(tx_byte_o));
  // Capture bytes handed to the application
  always @(posedge clk_i) begin
    if (rx_app_valid_o === 1'b1) begin
      app_b <= rx_app_byte_o;
      app_c <= rx_app_cmd_o;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic bus cycle, read data left in rd
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 40) n_fail++;
  endtask
  task automatic flag(input logic e);
    wb(1'b0, VBL_OFS_FLAG, 32'h0);
    chk("locked flag", rd & 32'h1, {31'h0, e});
  endtask
  task automatic t_regs;
    wb(1'b0, VBL_OFS_CONTROL, 32'h0);
    chk("control reset", rd, 32'h0);
    chk("port mode", {31'h0, port_mode_o}, 32'h1);
    flag(1'b0);
    wb(1'b0, VBL_OFS_OWN_ADDR, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task automatic t_lock;
    logic [3:0] lc [3] = '{VBL_CC_READ_LOCK, VBL_CC_CMD_LOCK, VBL_CC_WRITE_LOCK};
    logic [3:0] oc [4] = '{VBL_CC_STATUS, VBL_CC_ADDR_LO, VBL_CC_ADDR_HI, VBL_CC_WRITE};
    foreach (lc[i]) begin
      um.frame(lc[i], 12'h5a3, 1'b0, 2, 2'd1, 8'h11, ak);
      flag(1'b1);
      um.frame(lc[i], 12'h5a3, 1'b0, 1, 2'd0, 8'h22, ak);
      flag(1'b0);
    end
    um.frame(VBL_CC_WRITE_LOCK, 12'h5a3, 1'b0, 2, 2'd1, 8'h11, ak);
    wb(1'b0, VBL_OFS_LOCK_LO, 32'h0);
    chk("lock addr lo", rd & 32'hff, 32'ha3);
    wb(1'b0, VBL_OFS_LOCK_HI, 32'h0);
    chk("lock addr hi", rd & 32'h0f, 32'h5);
    foreach (oc[i]) begin
      um.frame(oc[i], 12'h111, 1'b0, 1, 2'd0, 8'h33, ak);
      chk("other ack", {31'h0, ak}, {31'h0, i < 3});
    end
    um.frame(VBL_CC_WRITE, 12'h5a3, 1'b0, 1, 2'd0, 8'h44, ak);
    chk("locker ack", {31'h0, ak}, 32'h1);
    flag(1'b1);
    um.frame(VBL_CC_STATUS_UNLOCK, 12'h5a3, 1'b0, 1, 2'd0, 8'h00, ak);
    flag(1'b0);
  endtask
  task automatic t_no_lock;
    um.frame(VBL_CC_WRITE_LOCK, 12'h5a3, 1'b0, 2, 2'd2, 8'h11, ak);
    flag(1'b0);
    um.frame(VBL_CC_WRITE_LOCK, 12'h5a3, 1'b1, 2, 2'd1, 8'h11, ak);
    flag(1'b0);
    um.frame(VBL_CC_WRITE_LOCK, 12'h5a3, 1'b0, 2, 2'd1, 8'h11, ak);
    um.frame(VBL_CC_WRITE_LOCK, 12'h5a3, 1'b1, 1, 2'd0, 8'h11, ak);
    flag(1'b1);
    wb(1'b1, VBL_OFS_COMMAND, {24'h0, VBL_CMD_UNLOCK});
    flag(1'b0);
    um.frame(VBL_CC_CMD_LOCK, 12'h5a3, 1'b0, 2, 2'd1, 8'h11, ak);
    @(posedge clk_i) module_stop_i <= 1'b1;
    @(posedge clk_i) module_stop_i <= 1'b0;
    flag(1'b0);
    um.frame(VBL_CC_CMD_LOCK, 12'h5a3, 1'b0, 2, 2'd1, 8'h11, ak);
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    flag(1'b0);
  endtask
  task automatic t_dispatch;
    wb(1'b1, VBL_OFS_TX_DATA, 32'h3c);
    um.frame(VBL_CC_READ, 12'h222, 1'b0, 1, 2'd0, 8'h00, ak);
    chk("tx byte", {24'h0, um.last_tx}, 32'h3c);
    um.frame(VBL_CC_CMD, 12'h222, 1'b0, 1, 2'd0, 8'h96, ak);
    chk("app cmd", {23'h0, app_c, app_b}, 32'h196);
    um.frame(VBL_CC_WRITE, 12'h222, 1'b0, 1, 2'd0, 8'h69, ak);
    wb(1'b0, VBL_OFS_RX_DATA, 32'h0);
    chk("rx data", rd & 32'hff, 32'h69);
  endtask
  task automatic t_bit;
    int gap [4] = '{5, 15, 20, 13};
    logic [3:0] lv;
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, VBL_OFS_CONTROL, {24'h0, 1'b1, k[0], 6'h0});
      wb(1'b0, VBL_OFS_CONTROL, 32'h0);
      chk("control", rd, {24'h0, 1'b1, k[0], 6'h0});
      chk("port mode", {31'h0, port_mode_o}, 32'h0);
      @(posedge clk_i) {bit_start_i, bit_value_i} <= {1'b1, ~k[0]};
      @(posedge clk_i) bit_start_i <= 1'b0;
      lv = {1'b1, 1'b0, ~k[0], 1'b1};
      for (int j = 0; j < 4; j++) begin
        repeat (gap[j]) @(posedge clk_i);
        chk("tx pin", {31'h0, bus_tx_o}, {31'h0, lv[3-j] ~^ k[0]});
      end
      bus_rx_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("rx logic", {31'h0, rx_logic_o}, {31'h0, k[0]});
      bus_rx_i <= 1'b0;
      repeat (10) @(posedge clk_i);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_lock();
    t_no_lock();
    t_dispatch();
    t_bit();
    final_report();
  end
endmodule
`default_nettype wire

// ===== sim/vbl_lock_ctrl_monitor.sv
// Checker for the lock controller: bus handshake, frame answers and pins.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module vbl_lock_ctrl_mon
  import vbl_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Frame events and answers
  input wire logic ctl_valid_i,
  input wire logic [3:0] ctl_code_i,
  input wire logic ctl_broadcast_i,
  input wire logic ctl_ack_o,
  input wire logic ctl_dir_m2s_o,
  input wire logic tx_byte_req_i,
  input wire logic tx_byte_valid_o,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_app_valid_o,
  input wire logic [7:0] rx_app_byte_o,
  // Bit shaper and pins
  input wire logic bit_busy_o,
  input wire logic bit_done_o,
  input wire logic bus_tx_o,
  input wire logic port_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Steps of a bus access and of a bit
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_bit_body;
    bit_busy_o [*8];
  endsequence
  a_wb_ack_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack late or long");
  a_status_always: assert property (ctl_valid_i && ctl_code_i == VBL_CC_STATUS && !ctl_broadcast_i |=> ctl_ack_o)
    else $error("status read refused");
  a_dir_from_code: assert property (ctl_valid_i ##1 ctl_ack_o |-> ctl_dir_m2s_o == $past(ctl_code_i[VBL_CC_DIR_BIT]))
    else $error("direction wrong");
  a_tx_answer: assert property (tx_byte_req_i |=> tx_byte_valid_o)
    else $error("tx byte not supplied");
  a_rx_handoff: assert property (rx_byte_valid_i |=> rx_app_valid_o && rx_app_byte_o == $past(rx_byte_i))
    else $error("rx byte not handed on");
  a_pin_parked: assert property (port_mode_o |-> !bus_tx_o)
    else $error("tx pin driven in port mode");
  a_bit_length: assert property ($rose(bit_busy_o) |-> s_bit_body ##[40:50] bit_done_o)
    else $error("bit length wrong");
  a_done_ends: assert property (bit_done_o |-> !$past(bit_done_o))
    else $error("done pulse long");
endmodule
bind vbl_lock_ctrl vbl_lock_ctrl_mon mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ctl_valid_i, .ctl_code_i,
  .ctl_broadcast_i, .ctl_ack_o, .ctl_dir_m2s_o, .tx_byte_req_i, .tx_byte_valid_o, .rx_byte_valid_i, .rx_byte_i,
  .rx_app_valid_o, .rx_app_byte_o, .bit_busy_o, .bit_done_o, .bus_tx_o, .port_mode_o);
`default_nettype wire

// ===== sim/vbl_unit_model.sv
// Model of another unit on the bus, seen through the frame decoder events.
// Assumes the slave answers one cycle after each event pulse.
`timescale 1ns/1ps
`default_nettype none
module vbl_unit_model
  import vbl_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Frame events toward the slave
  output logic ctl_valid_o,
  output logic [3:0] ctl_code_o,
  output logic [11:0] ctl_master_o,
  output logic ctl_broadcast_o,
  output logic len_ack_o,
  output logic frame_end_o,
  output logic frame_complete_o,
  output logic frame_overflow_o,
  output logic rx_byte_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_byte_req_o,
  // Answers from the slave
  input wire logic ctl_ack_i,
  input wire logic tx_byte_valid_i,
  input wire logic [7:0] tx_byte_i
);
  logic [7:0] last_tx = 8'h00;
  initial begin
    {ctl_valid_o, ctl_code_o, ctl_master_o, ctl_broadcast_o, len_ack_o, frame_end_o} = '0;
    {frame_complete_o, frame_overflow_o, rx_byte_valid_o, rx_byte_o, tx_byte_req_o} = '0;
  end
  // Keep what the slave sent
  always @(posedge clk_i) begin
    if (tx_byte_valid_i === 1'b1) last_tx <= tx_byte_i;
  end
  // One frame; how: 0 complete, 1 overflow, 2 other error
  task automatic frame(input logic [3:0] code, input logic [11:0] who, input logic bc, input int nb,
                       input logic [1:0] how, input logic [7:0] d, output logic acked);
    @(posedge clk_i);
    ctl_valid_o <= 1'b1;
    ctl_code_o <= code;
    ctl_master_o <= who;
    ctl_broadcast_o <= bc;
    @(posedge clk_i);
    ctl_valid_o <= 1'b0;
    @(posedge clk_i);
    acked = ctl_ack_i | bc;
    if (acked) begin
      len_ack_o <= 1'b1;
      @(posedge clk_i);
      len_ack_o <= 1'b0;
      repeat (nb) begin
        if (code[VBL_CC_DIR_BIT]) begin
          rx_byte_valid_o <= 1'b1;
          rx_byte_o <= d;
        end else tx_byte_req_o <= 1'b1;
        @(posedge clk_i);
        rx_byte_valid_o <= 1'b0;
        tx_byte_req_o <= 1'b0;
        rx_byte_o <= ~d;
        @(posedge clk_i);
      end
    end
    frame_end_o <= 1'b1;
    frame_complete_o <= acked && how == 2'd0;
    frame_overflow_o <= acked && how == 2'd1;
    @(posedge clk_i);
    {frame_end_o, frame_complete_o, frame_overflow_o} <= 3'b000;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire
